// ==== hcmr_board_model.sv ====
// Purpose: board-side partner of the register bank: dma controller, address decoder, port loopback
// Assumes: one clock, pins change one stimulus delay after the rising edge
// Notes: acknowledge drops as soon as every request line is released
`timescale 1ns/10ps
module hcmr_board_model
  import hcmr_pkg::*;
#(
  parameter int ACK_DELAY = 3
)
(
  input wire logic clk,
  input wire logic [2:0] drqOut,
  input wire logic [31:0] memAddr,
  input wire logic [7:0] ioPortOut,
  output logic dmaAckPin,
  output logic extMemDecodeN,
  output logic [7:0] ioPortIn
);
  int cnt = 0; // cycles a request has waited
  initial dmaAckPin = 1'b0;
  // dma controller: grant after a few cycles, withdraw at once when the request goes
  always @(posedge clk) begin
    #1;
    if (|drqOut) begin
      cnt = (cnt < ACK_DELAY) ? cnt + 1 : cnt;
    end else begin
      cnt = 0;
    end
    dmaAckPin = (cnt >= ACK_DELAY);
  end
  // outside decoder of the top address byte, active low
  assign extMemDecodeN = (memAddr[31:24] != 8'h00);
  // inputs wired back inverted so a stuck port cannot pass for a good one
  assign ioPortIn = ~ioPortOut;
endmodule

// ==== hcmr_mailbox.sv ====
// Purpose: one command mailbox shared by host and local processor, with busy flag and interrupts
// Assumes: write strobes and firmware reset come from logic on the same clock
// Notes: host write takes precedence over a coincident processor write
`timescale 1ns/10ps
module hcmr_mailbox
  import hcmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fwReset,
  input wire logic hostWr,
  input wire logic [7:0] hostData,
  input wire logic mpuWr,
  input wire logic [7:0] mpuData,
  input wire logic irqMask,
  output logic [7:0] value,
  output logic mpuIrq,
  output logic hostIrq
);

  // mailbox state
  typedef struct packed {
    logic [7:0] val;
    logic hostIrq;
  } hcmr_mbx_s;

  hcmr_mbx_s mbx_reg;
  hcmr_mbx_s mbx_next;

  // next state: resets only set busy, low bits are left alone
  always_comb begin
    mbx_next = mbx_reg;
    mbx_next.hostIrq = 1'b0;
    if (rst || fwReset) begin
      mbx_next.val[MBX_BUSY_BIT] = 1'b1;
    end else if (hostWr) begin
      // host first, so a clash never leaves a half-merged value
      mbx_next.val = hostData;
    end else if (mpuWr) begin
      mbx_next.val = mpuData;
      // processor finishing a command: busy dropped by its write
      mbx_next.hostIrq = mbx_reg.val[MBX_BUSY_BIT] & ~mpuData[MBX_BUSY_BIT];
    end
  end

  // one register stage for the whole mailbox
  always_ff @(posedge clk) begin
    mbx_reg <= mbx_next;
  end

  assign value = mbx_reg.val;
  assign mpuIrq = mbx_reg.val[MBX_BUSY_BIT] & ~irqMask;
  assign hostIrq = mbx_reg.hostIrq;

endmodule

// ==== hcmr_pkg.sv ====
// Purpose: shared constants and types of the host configuration and mailbox register bank
// Assumes: 5-bit register index on both the host and the local processor register ports
// Notes: offsets are register indexes as printed; every field position and count is named here once
package hcmr_pkg;

  // register indexes
  localparam logic [4:0] OFS_ARB_CFG = 5'h05;
  localparam logic [4:0] OFS_PROM_RANGE = 5'h06;
  localparam logic [4:0] OFS_IO_PORT = 5'h07;
  localparam logic [4:0] OFS_MBX0 = 5'h08;
  localparam logic [4:0] OFS_MBX1 = 5'h09;
  localparam logic [4:0] OFS_MBX2 = 5'h0A;
  localparam logic [4:0] OFS_DATA0 = 5'h0B;
  localparam logic [4:0] OFS_DATA1 = 5'h0C;
  localparam logic [4:0] OFS_DATA2 = 5'h0D;

  // arbitration configuration fields
  localparam int ARB_LEVEL_LSB = 0;
  localparam int ARB_LEVEL_W = 4;
  localparam int ARB_ALGO_BIT = 4;
  localparam int ARB_WAIT_BIT = 4;
  localparam int ARB_IO16_BIT = 5;
  localparam int ARB_CHK_STATUS_BIT = 6;
  localparam int ARB_CHK_BIT = 7;
  localparam logic [7:0] ARB_CFG_RESET = 8'h00;

  // dma request line patterns in the low arbitration bits
  localparam logic [3:0] DRQ0_PATTERN = 4'h1;
  localparam logic [3:0] DRQ1_PATTERN = 4'h2;
  localparam logic [3:0] DRQ2_PATTERN = 4'h4;

  // delay after dma acknowledge, in device clocks
  localparam int AT_WAIT_SHORT_CLKS = 10;
  localparam int AT_WAIT_LONG_CLKS = 20;

  // prom range fields and decode
  localparam int PROM_ADDR_LSB = 1;
  localparam int PROM_SIZE_LSB = 6;
  localparam logic [6:0] PROM_FIXED_HIGH = 7'h06;
  localparam logic [3:0] NUBUS_HEX_F = 4'hF;

  // mailbox busy flag and mailbox count
  localparam int MBX_BUSY_BIT = 7;
  localparam int MBX_COUNT = 3;

  // host bus flavour, strapped by the board
  typedef enum logic [1:0] {CHANNEL_HOST_MODE, AT_MODE, EISA_MODE, NUBUS_MODE} hcmr_mode_e;

  // post-acknowledge wait sequencer
  typedef enum logic [1:0] {WAIT_IDLE, WAIT_COUNT, WAIT_GO} hcmr_wait_e;

  // whole state of the main register bank
  typedef struct packed {
    logic [7:0] arbCfg;
    logic [7:0] promRange;
    logic promWritten;
    logic [7:0] ioOut;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [7:0] data2;
    logic ackS1;
    logic ackS2;
    logic [7:0] inS1;
    logic [7:0] inS2;
    hcmr_wait_e waitSt;
    logic [4:0] waitCnt;
    logic [7:0] hostRd;
    logic [7:0] mpuRd;
    logic promHit;
  } hcmr_state_s;

endpackage

// ==== hcmr_regs.sv ====
// Purpose: host configuration, prom decode, general port, mailboxes and host-to-processor data
// Assumes: host and processor register ports are synchronous to clk; mode and slot pins are static straps
// Notes: read data appears one clock after the request and holds until the next read
// Contract
// - low arbitration bits set channel-host priority
// - at mode low bits pick dma request
// - eisa mode asserts master request when needed
// - bit four selects fairness or linear arbitration
// - at wait ten or twenty clocks after acknowledge
// - sixteen-bit option turns upper lines into port
// - bit seven drives the channel check signal
// - prom ignored until range register written
// - prom range survives both resets
// - prom match on fixed high address bits
// - size field limits decoded address bits
// - external decode input gates wide prom accesses
// - port writes outputs, reads raw inputs
// - general port survives both resets
// - resets set mailbox busy, keep low bits
// - busy bit interrupts processor unless masked
// - processor clearing busy interrupts the host
// - data registers host-written, processor-read, kept
// - nubus prom decode uses slot and window
// - nubus priority comes from slot pins
// - arbitration register cleared by hard reset
`timescale 1ns/10ps
module hcmr_regs
  import hcmr_pkg::*;
#(
  parameter int WAIT_CNT_W = 5
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fwReset,
  input wire hcmr_mode_e busMode,
  input wire logic [3:0] slotId,
  input wire logic hostSel,
  input wire logic hostWr,
  input wire logic [4:0] hostAddr,
  input wire logic [7:0] hostWdata,
  output logic [7:0] hostRdata,
  input wire logic mpuSel,
  input wire logic mpuWr,
  input wire logic [4:0] mpuAddr,
  input wire logic [7:0] mpuWdata,
  output logic [7:0] mpuRdata,
  input wire logic [2:0] mbxIrqMask,
  output logic [2:0] mpuIrq,
  output logic [2:0] hostIrq,
  input wire logic needBus,
  input wire logic dmaAckPin,
  output logic [3:0] arbLevel,
  output logic linearArb,
  output logic [2:0] drqOut,
  output logic masterReqN,
  output logic busGo,
  output logic chkStatus,
  output logic channelCheck,
  output logic ioChannelCheck,
  output logic [7:0] ioPortOut,
  output logic ioPortOeN,
  input wire logic [7:0] ioPortIn,
  input wire logic [31:0] memAddr,
  input wire logic memAccess,
  input wire logic addr24SelectFlag,
  input wire logic extMemDecodeN,
  output logic promHit
);

  // counter must hold the longest wait
  if ((1 << WAIT_CNT_W) <= AT_WAIT_LONG_CLKS) begin : g_bad_width
    $error("WAIT_CNT_W too small for the acknowledge wait");
  end

  hcmr_state_s st_reg;
  hcmr_state_s st_next;

  logic [7:0] mbxVal [MBX_COUNT]; // mailbox contents
  logic [2:0] mbxBusy; // busy flags, one per mailbox
  logic [2:0] hostMbxWr; // host write strobe per mailbox
  logic [2:0] mpuMbxWr; // processor write strobe per mailbox
  logic portAvail; // general port present in this mode
  logic hostWrEn; // host write this cycle
  logic mpuWrEn; // processor write this cycle

  // loads two short of the wait: the entry edge and the go edge count as clocks too
  localparam logic [4:0] WAIT_SHORT_LOAD = 5'(AT_WAIT_SHORT_CLKS - 2);
  localparam logic [4:0] WAIT_LONG_LOAD = 5'(AT_WAIT_LONG_CLKS - 2);

  // prom window compare; size hides the low range bits
  function automatic logic promMatch(input logic [7:0] range, input logic [31:0] a);
    logic [3:0] care;
    care = 4'hF;
    unique case (range[PROM_SIZE_LSB +: 2])
      2'b00: care = 4'hF; // 8K
      2'b01: care = 4'hE; // 16K
      2'b10: care = 4'hC; // 32K
      2'b11: care = 4'h8; // 64K, A16 still decoded
    endcase
    promMatch = (a[23:17] == PROM_FIXED_HIGH) &&
                (((a[16:13] ^ range[PROM_ADDR_LSB +: 4]) & care) == 4'h0);
  endfunction

  // read decode shared by both ports; unmapped reads return zero
  function automatic logic [7:0] readMux(input hcmr_state_s s, input logic [4:0] a, input logic fromHost,
                                         input logic [23:0] mbx, input logic avail);
    readMux = 8'h00;
    unique case (a)
      OFS_ARB_CFG: readMux = s.arbCfg;
      OFS_PROM_RANGE: readMux = s.promRange;
      OFS_IO_PORT: readMux = avail ? s.inS2 : 8'h00;
      OFS_MBX0: readMux = mbx[7:0];
      OFS_MBX1: readMux = mbx[15:8];
      OFS_MBX2: readMux = mbx[23:16];
      // data registers read by the processor only
      OFS_DATA0: readMux = fromHost ? 8'h00 : s.data0;
      OFS_DATA1: readMux = fromHost ? 8'h00 : s.data1;
      OFS_DATA2: readMux = fromHost ? 8'h00 : s.data2;
      default: readMux = 8'h00;
    endcase
  endfunction

  assign hostWrEn = hostSel & hostWr;
  assign mpuWrEn = mpuSel & mpuWr;
  // port always there on nubus, otherwise behind the sixteen-bit option
  assign portAvail = (busMode == NUBUS_MODE) | st_reg.arbCfg[ARB_IO16_BIT];

  // mailbox write strobes by index
  always_comb begin
    hostMbxWr = {hostWrEn && hostAddr == OFS_MBX2, hostWrEn && hostAddr == OFS_MBX1,
                 hostWrEn && hostAddr == OFS_MBX0};
    mpuMbxWr = {mpuWrEn && mpuAddr == OFS_MBX2, mpuWrEn && mpuAddr == OFS_MBX1,
                mpuWrEn && mpuAddr == OFS_MBX0};
  end

  // three identical mailboxes
  for (genvar i = 0; i < MBX_COUNT; i++) begin : g_mbx
    hcmr_mailbox u_mbx (
      .clk(clk),
      .rst(rst),
      .fwReset(fwReset),
      .hostWr(hostMbxWr[i]),
      .hostData(hostWdata),
      .mpuWr(mpuMbxWr[i]),
      .mpuData(mpuWdata),
      .irqMask(mbxIrqMask[i]),
      .value(mbxVal[i]),
      .mpuIrq(mpuIrq[i]),
      .hostIrq(hostIrq[i])
    );
    assign mbxBusy[i] = mbxVal[i][MBX_BUSY_BIT];
  end

  // next-state logic for the whole bank
  always_comb begin
    st_next = st_reg;
    // synchronisers for pins from outside the clock domain
    st_next.ackS1 = dmaAckPin;
    st_next.ackS2 = st_reg.ackS1;
    st_next.inS1 = ioPortIn;
    st_next.inS2 = st_reg.inS1;

    // arbitration register: host write wins a clash
    if (hostWrEn && hostAddr == OFS_ARB_CFG) begin
      st_next.arbCfg = hostWdata;
    end else if (mpuWrEn && mpuAddr == OFS_ARB_CFG) begin
      st_next.arbCfg = mpuWdata;
    end

    // prom range; first write opens the decode
    if (hostWrEn && hostAddr == OFS_PROM_RANGE) begin
      st_next.promRange = hostWdata;
      st_next.promWritten = 1'b1;
    end else if (mpuWrEn && mpuAddr == OFS_PROM_RANGE) begin
      st_next.promRange = mpuWdata;
      st_next.promWritten = 1'b1;
    end

    // general port outputs; write ignored when the port is absent
    if (portAvail) begin
      if (hostWrEn && hostAddr == OFS_IO_PORT) begin
        st_next.ioOut = hostWdata;
      end else if (mpuWrEn && mpuAddr == OFS_IO_PORT) begin
        st_next.ioOut = mpuWdata;
      end
    end

    // data registers written by the host only
    if (hostWrEn) begin
      unique case (hostAddr)
        OFS_DATA0: st_next.data0 = hostWdata;
        OFS_DATA1: st_next.data1 = hostWdata;
        OFS_DATA2: st_next.data2 = hostWdata;
        default: ;
      endcase
    end

    // registered read data, held until the next read
    if (hostSel && !hostWr) begin
      st_next.hostRd = readMux(st_reg, hostAddr, 1'b1, {mbxVal[2], mbxVal[1], mbxVal[0]}, portAvail);
    end
    if (mpuSel && !mpuWr) begin
      st_next.mpuRd = readMux(st_reg, mpuAddr, 1'b0, {mbxVal[2], mbxVal[1], mbxVal[0]}, portAvail);
    end

    // prom select, registered from the current bus address
    st_next.promHit = 1'b0;
    if (memAccess) begin
      unique case (busMode)
        NUBUS_MODE: begin
          // fixed hex digits, slot id, don't-care digit, 64K window
          st_next.promHit = (memAddr[31:28] == NUBUS_HEX_F) && (memAddr[27:24] == slotId) &&
                            (memAddr[19:16] == NUBUS_HEX_F);
        end
        EISA_MODE: begin
          st_next.promHit = st_reg.promWritten && promMatch(st_reg.promRange, memAddr) &&
                            !extMemDecodeN;
        end
        CHANNEL_HOST_MODE: begin
          // wide addressing needs the outside decode as well
          st_next.promHit = st_reg.promWritten && promMatch(st_reg.promRange, memAddr) &&
                            (addr24SelectFlag || !extMemDecodeN);
        end
        AT_MODE: begin
          st_next.promHit = st_reg.promWritten && promMatch(st_reg.promRange, memAddr);
        end
      endcase
    end

    // wait from dma acknowledge to bus access, at mode only
    unique case (st_reg.waitSt)
      WAIT_IDLE: begin
        if (busMode == AT_MODE && st_reg.ackS2) begin
          st_next.waitSt = WAIT_COUNT;
          // bit set gives the short wait
          st_next.waitCnt = st_reg.arbCfg[ARB_WAIT_BIT] ? WAIT_SHORT_LOAD : WAIT_LONG_LOAD;
        end
      end
      WAIT_COUNT: begin
        if (!st_reg.ackS2) begin
          st_next.waitSt = WAIT_IDLE;
        end else if (st_reg.waitCnt == 5'h00) begin
          st_next.waitSt = WAIT_GO;
        end else begin
          st_next.waitCnt = st_reg.waitCnt - 5'h01;
        end
      end
      WAIT_GO: begin
        // access lasts as long as the acknowledge
        if (!st_reg.ackS2) begin
          st_next.waitSt = WAIT_IDLE;
        end
      end
      // unused code falls back to idle
      default: st_next.waitSt = WAIT_IDLE;
    endcase

    // hard reset: range, port and data are deliberately kept
    if (rst) begin
      st_next.arbCfg = ARB_CFG_RESET;
      st_next.promWritten = 1'b0;
      st_next.ackS1 = 1'b0;
      st_next.ackS2 = 1'b0;
      st_next.inS1 = 8'h00;
      st_next.inS2 = 8'h00;
      st_next.waitSt = WAIT_IDLE;
      st_next.waitCnt = 5'h00;
      st_next.hostRd = 8'h00;
      st_next.mpuRd = 8'h00;
      st_next.promHit = 1'b0;
    end
  end

  // single register stage
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // arbitration outputs by bus flavour
  always_comb begin
    // nubus takes its priority from the slot pins
    arbLevel = (busMode == NUBUS_MODE) ? slotId : st_reg.arbCfg[ARB_LEVEL_LSB +: ARB_LEVEL_W];
    linearArb = (busMode == CHANNEL_HOST_MODE) && st_reg.arbCfg[ARB_ALGO_BIT];
    drqOut = 3'b000;
    if (busMode == AT_MODE && needBus) begin
      // only the three legal one-hot patterns drive a line
      unique case (st_reg.arbCfg[ARB_LEVEL_LSB +: ARB_LEVEL_W])
        DRQ0_PATTERN: drqOut = 3'b001;
        DRQ1_PATTERN: drqOut = 3'b010;
        DRQ2_PATTERN: drqOut = 3'b100;
        default: drqOut = 3'b000;
      endcase
    end
    masterReqN = !((busMode == EISA_MODE) && needBus);
  end

  assign busGo = (st_reg.waitSt == WAIT_GO);
  assign chkStatus = (busMode == CHANNEL_HOST_MODE) && st_reg.arbCfg[ARB_CHK_STATUS_BIT];
  assign channelCheck = (busMode == CHANNEL_HOST_MODE) && st_reg.arbCfg[ARB_CHK_BIT];
  assign ioChannelCheck = (busMode == AT_MODE) && st_reg.arbCfg[ARB_CHK_BIT];
  assign ioPortOut = st_reg.ioOut;
  assign ioPortOeN = !portAvail;
  assign hostRdata = st_reg.hostRd;
  assign mpuRdata = st_reg.mpuRd;
  assign promHit = st_reg.promHit;

  // checks
  a_nubus_priority: assert property (@(posedge clk) disable iff (rst)
    busMode == NUBUS_MODE |-> arbLevel == slotId)
    else $error("nubus priority not from slot pins");
  a_drq_onehot: assert property (@(posedge clk) disable iff (rst)
    drqOut != 3'b000 |-> busMode == AT_MODE && needBus && $onehot(drqOut))
    else $error("dma request driven without cause");
  a_master_request: assert property (@(posedge clk) disable iff (rst)
    !masterReqN |-> busMode == EISA_MODE && needBus)
    else $error("master request asserted without need");
  a_wait_short: assert property (@(posedge clk) disable iff (rst)
    $rose(busGo) && st_reg.arbCfg[ARB_WAIT_BIT] |->
      $past(st_reg.ackS2, 10) && !$past(st_reg.ackS2, 11) && !$past(busGo, 10))
    else $error("short acknowledge wait wrong");
  a_wait_long: assert property (@(posedge clk) disable iff (rst)
    $rose(busGo) && !st_reg.arbCfg[ARB_WAIT_BIT] |-> $past(st_reg.ackS2, 20) && !$past(st_reg.ackS2, 21))
    else $error("long acknowledge wait wrong");
  a_ack_no_early: assert property (@(posedge clk) disable iff (rst)
    $rose(st_reg.ackS2) && !busGo |-> !busGo [*8])
    else $error("bus access too soon after acknowledge");
  a_prom_locked: assert property (@(posedge clk) disable iff (rst)
    busMode != NUBUS_MODE && !st_reg.promWritten |=> !promHit)
    else $error("prom hit before range written");
  a_prom_extdec: assert property (@(posedge clk) disable iff (rst)
    busMode == EISA_MODE && extMemDecodeN |=> !promHit)
    else $error("prom hit without external decode");
  a_mbx_fwreset: assert property (@(posedge clk) disable iff (rst)
    fwReset |=> &mbxBusy && mbxVal[0][6:0] == $past(mbxVal[0][6:0]))
    else $error("firmware reset mailbox handling wrong");
  a_mpu_irq: assert property (@(posedge clk) disable iff (rst)
    mbxBusy[1] && !mbxIrqMask[1] |-> mpuIrq[1])
    else $error("busy mailbox without processor interrupt");
  a_host_irq: assert property (@(posedge clk) disable iff (rst)
    mbxBusy[0] && mpuMbxWr[0] && !hostMbxWr[0] && !fwReset && !mpuWdata[7] |=> hostIrq[0])
    else $error("host interrupt missing on command done");
  a_channel_check_level: assert property (@(posedge clk) disable iff (rst)
    channelCheck || ioChannelCheck |-> st_reg.arbCfg[ARB_CHK_BIT])
    else $error("channel check without control bit");
  a_arb_reset: assert property (@(posedge clk)
    rst |=> st_reg.arbCfg == ARB_CFG_RESET && !busGo)
    else $error("arbitration register not cleared");

  c_go: cover property (@(posedge clk) disable iff (rst) $rose(busGo));
  c_prom: cover property (@(posedge clk) disable iff (rst) promHit);
  c_mbx_done: cover property (@(posedge clk) disable iff (rst) hostIrq[0]);
  c_clash: cover property (@(posedge clk) disable iff (rst) hostMbxWr[1] && mpuMbxWr[1]);

endmodule

// ==== hcmr_regs_test.sv ====
// Purpose: self-checking bench of the host configuration and mailbox register bank
// Assumes: host and processor ports driven one delay after the rising edge
// Notes: outputs are sampled a delay after the edge or on the falling edge, except the host irq count and irq clear checks, taken at the rising edge
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module hcmr_regs_test;
  import hcmr_pkg::*;
  localparam time DLY = 1; // stimulus delay after the edge
  logic clk, rst, fwReset, hostSel, hostWr, mpuSel, mpuWr, needBus, memAccess, addr24SelectFlag;
  logic dmaAckPin, extMemDecodeN, promHit, linearArb, masterReqN, busGo, chkStatus, channelCheck;
  logic ioChannelCheck, ioPortOeN;
  hcmr_mode_e busMode;
  logic [3:0] slotId, arbLevel;
  logic [4:0] hostAddr, mpuAddr;
  logic [7:0] hostWdata, hostRdata, mpuWdata, mpuRdata, ioPortOut, ioPortIn, rd;
  logic [2:0] mbxIrqMask, mpuIrq, hostIrq, drqOut;
  logic [31:0] memAddr;
  int n_fail = 0;
  int compares = 0;
  int irqCnt = 0; // host interrupt pulses of mailbox 0
  hcmr_regs hcmr_regs_inst (.clk(clk), .rst(rst), .fwReset(fwReset), .busMode(busMode), .slotId(slotId),
    .hostSel(hostSel), .hostWr(hostWr), .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata),
    .mpuSel(mpuSel), .mpuWr(mpuWr), .mpuAddr(mpuAddr), .mpuWdata(mpuWdata), .mpuRdata(mpuRdata),
    .mbxIrqMask(mbxIrqMask), .mpuIrq(mpuIrq), .hostIrq(hostIrq), .needBus(needBus), .dmaAckPin(dmaAckPin),
    .arbLevel(arbLevel), .linearArb(linearArb), .drqOut(drqOut), .masterReqN(masterReqN), .busGo(busGo),
    .chkStatus(chkStatus), .channelCheck(channelCheck), .ioChannelCheck(ioChannelCheck),
    .ioPortOut(ioPortOut), .ioPortOeN(ioPortOeN), .ioPortIn(ioPortIn), .memAddr(memAddr),
    .memAccess(memAccess), .addr24SelectFlag(addr24SelectFlag), .extMemDecodeN(extMemDecodeN),
    .promHit(promHit));
  hcmr_board_model hcmr_board_model_inst (.clk(clk), .drqOut(drqOut), .memAddr(memAddr),
    .ioPortOut(ioPortOut), .dmaAckPin(dmaAckPin), .extMemDecodeN(extMemDecodeN), .ioPortIn(ioPortIn));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // pulse counter sampled mid-cycle, so a one-cycle pulse is seen exactly once
  always @(negedge clk) if (hostIrq[0] === 1'b1) irqCnt++;
  // one register access on either port; read data is taken after the answering edge
  task automatic xfer(input bit m, input bit w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #DLY;
    if (m) begin
      mpuSel = 1'b1; mpuWr = w; mpuAddr = a; mpuWdata = d;
    end else begin
      hostSel = 1'b1; hostWr = w; hostAddr = a; hostWdata = d;
    end
    @(posedge clk);
    #DLY;
    mpuSel = 1'b0;
    hostSel = 1'b0;
    rd = m ? mpuRdata : hostRdata;
  endtask
  task automatic wr(input bit m, input logic [4:0] a, input logic [7:0] d);
    xfer(m, 1'b1, a, d);
  endtask
  task automatic rdr(input bit m, input logic [4:0] a);
    xfer(m, 1'b0, a, 8'h00);
  endtask
  // one memory cycle; the select answers in the following cycle
  task automatic prom(input logic [31:0] a, input logic ex);
    @(posedge clk);
    #DLY;
    memAccess = 1'b1; memAddr = a;
    @(posedge clk);
    #DLY;
    memAccess = 1'b0;
    `CHK("prom select", ex, promHit)
  endtask
  // cycles from acknowledge to bus grant: two sync stages, one falling-edge offset, plus the wait
  task automatic ackWait(input int waitClks);
    int n;
    n = 0;
    needBus = 1'b1;
    @(posedge dmaAckPin);
    do begin
      @(negedge clk);
      n++;
    end while (busGo !== 1'b1 && n < 100);
    `CHK("ack wait", waitClks + 3, n)
    @(posedge clk);
    #DLY;
    needBus = 1'b0;
    repeat (8) @(posedge clk);
    #DLY;
  endtask
  task automatic hardReset();
    @(posedge clk);
    #DLY;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #DLY;
    rst = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    #(40 * 20000);
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst = 1'b1; fwReset = 1'b0; busMode = CHANNEL_HOST_MODE; slotId = 4'h9;
    hostSel = 1'b0; hostWr = 1'b0; hostAddr = 5'h00; hostWdata = 8'h00;
    mpuSel = 1'b0; mpuWr = 1'b0; mpuAddr = 5'h00; mpuWdata = 8'h00;
    mbxIrqMask = 3'h0; needBus = 1'b0; memAccess = 1'b0; memAddr = 32'h0; addr24SelectFlag = 1'b1;
    repeat (4) @(posedge clk);
    #DLY;
    rst = 1'b0;
    rdr(0, OFS_ARB_CFG); `CHK("arb reset", 8'h00, rd)
    `CHK("busy irq", 3'h7, mpuIrq)
    prom(32'h000C0000, 1'b0);
    // channel-host arbitration fields
    wr(1, OFS_ARB_CFG, 8'hDA);
    `CHK("priority", 4'hA, arbLevel)
    `CHK("linear", 1'b1, linearArb)
    `CHK("check", 1'b1, channelCheck)
    `CHK("check status", 1'b1, chkStatus)
    rdr(0, OFS_ARB_CFG); `CHK("arb rd", 8'hDA, rd)
    wr(0, OFS_ARB_CFG, {2'b00, rd[5:0]});
    `CHK("check off", 1'b0, channelCheck)
    `CHK("level kept", 4'hA, arbLevel)
    wr(1, OFS_ARB_CFG, 8'h0F);
    `CHK("fairness", 1'b0, linearArb)
    `CHK("lowest", 4'hF, arbLevel)
    // at mode: each request line pattern, then both acknowledge waits
    busMode = AT_MODE;
    needBus = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(0, OFS_ARB_CFG, {4'h8, 4'h1 << i});
      `CHK("request line", 3'h1 << i, drqOut)
      `CHK("io check", 1'b1, ioChannelCheck)
    end
    needBus = 1'b0;
    repeat (8) @(posedge clk);
    wr(0, OFS_ARB_CFG, 8'h11);
    ackWait(AT_WAIT_SHORT_CLKS);
    wr(0, OFS_ARB_CFG, 8'h01);
    ackWait(AT_WAIT_LONG_CLKS);
    busMode = EISA_MODE;
    needBus = 1'b1;
    @(negedge clk);
    `CHK("master req", 1'b0, masterReqN)
    needBus = 1'b0;
    busMode = NUBUS_MODE;
    @(negedge clk);
    `CHK("slot priority", slotId, arbLevel)
    `CHK("port enable", 1'b0, ioPortOeN)
    // general port: reads zero while absent, then loops back inverted
    busMode = CHANNEL_HOST_MODE;
    wr(0, OFS_ARB_CFG, 8'h00);
    `CHK("port off", 1'b1, ioPortOeN)
    wr(0, OFS_IO_PORT, 8'h55);
    rdr(0, OFS_IO_PORT); `CHK("port absent", 8'h00, rd)
    wr(1, OFS_ARB_CFG, 8'h20);
    `CHK("port on", 1'b0, ioPortOeN)
    wr(1, OFS_IO_PORT, 8'h3C);
    `CHK("port out", 8'h3C, ioPortOut)
    repeat (4) @(posedge clk);
    rdr(0, OFS_IO_PORT); `CHK("port in", 8'hC3, rd)
    // mailboxes: mask, busy handshake, firmware reset, coincident writes
    mbxIrqMask = 3'b010;
    @(negedge clk);
    `CHK("masked irq", 3'b101, mpuIrq)
    wr(1, OFS_MBX0, 8'h12);
    repeat (2) @(posedge clk);
    `CHK("host irq", 1, irqCnt)
    `CHK("irq clear", 1'b0, mpuIrq[0])
    wr(0, OFS_MBX0, 8'h85);
    `CHK("cmd irq", 1'b1, mpuIrq[0])
    rdr(1, OFS_MBX0); `CHK("cmd", 8'h85, rd)
    wr(1, OFS_MBX0, 8'h12);
    repeat (2) @(posedge clk);
    `CHK("host irq 2", 2, irqCnt)
    @(posedge clk);
    #DLY;
    fwReset = 1'b1;
    @(posedge clk);
    #DLY;
    fwReset = 1'b0;
    rdr(0, OFS_MBX0); `CHK("fw busy", 8'h92, rd)
    @(posedge clk);
    #DLY;
    hostSel = 1'b1; hostWr = 1'b1; hostAddr = OFS_MBX1; hostWdata = 8'hA1;
    mpuSel = 1'b1; mpuWr = 1'b1; mpuAddr = OFS_MBX1; mpuWdata = 8'h33;
    @(posedge clk);
    #DLY;
    hostSel = 1'b0;
    mpuSel = 1'b0;
    rdr(1, OFS_MBX1); `CHK("coincident", 8'hA1, rd)
    // data registers: host writes, processor reads
    for (int i = 0; i < 3; i++) wr(0, OFS_DATA0 + 5'(i), 8'h40 + 8'(i));
    wr(1, OFS_DATA0, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      rdr(1, OFS_DATA0 + 5'(i)); `CHK("data", 8'h40 + 8'(i), rd)
    end
    rdr(0, OFS_DATA1); `CHK("data host rd", 8'h00, rd)
    rdr(1, 5'h1F); `CHK("unmapped", 8'h00, rd)
    // prom decode: 64K and 8K windows, outside decode, slot window
    wr(0, OFS_PROM_RANGE, 8'hC0);
    prom(32'h000CF000, 1'b1);
    prom(32'h000D0000, 1'b0);
    prom(32'h000E0000, 1'b0);
    wr(1, OFS_PROM_RANGE, 8'h10);
    prom(32'h000D1FFF, 1'b1);
    prom(32'h000D2000, 1'b0);
    addr24SelectFlag = 1'b0;
    prom(32'h010D0000, 1'b0);
    prom(32'h000D0000, 1'b1);
    addr24SelectFlag = 1'b1;
    busMode = EISA_MODE;
    prom(32'h000D0000, 1'b1);
    prom(32'h010D0000, 1'b0);
    busMode = NUBUS_MODE;
    prom({4'hF, slotId, 4'h3, 4'hF, 16'h1234}, 1'b1);
    prom({4'hF, 4'h2, 4'h3, 4'hF, 16'h1234}, 1'b0);
    // hard reset in mid-run: what survives and what clears
    busMode = CHANNEL_HOST_MODE;
    hardReset();
    rdr(0, OFS_ARB_CFG); `CHK("arb cleared", 8'h00, rd)
    rdr(0, OFS_PROM_RANGE); `CHK("range kept", 8'h10, rd)
    `CHK("port kept", 8'h3C, ioPortOut)
    rdr(1, OFS_DATA1); `CHK("data kept", 8'h41, rd)
    rdr(1, OFS_MBX0); `CHK("busy set", 8'h92, rd)
    prom(32'h000D0000, 1'b0);
    report_and_stop();
  end
endmodule
